/* File: core/tbpc_top.sv */
`timescale 1ns/1ns

module tbpc_top
  import tbpc_pkg::*;
#(
  parameter int unsigned NCH = CHAN_N
) (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  // shared period timer
  input  wire logic [TMR_W-1:0]  base_timer_count_in,
  input  wire logic [LOW_W-1:0]  time_base_low_in,
  input  wire logic [TMR_W-1:0]  period_value_reg_in,
  input  wire logic              timer_period_match_in,
  // waveforms to pin routing and peripherals
  output logic      [NCH-1:0]    channel_wave_out
);

  tbpc_regs_t               q;
  tbpc_regs_t               d;
  tbpc_timer_t              timer_s;
  logic [NCH-1:0]           wave_s;
  logic [DUTY_W-1:0]        wr_duty;

  // timer signals come from logic on this clock, so no synchroniser
  assign timer_s.count  = base_timer_count_in;
  assign timer_s.low    = time_base_low_in;
  assign timer_s.period = period_value_reg_in;
  assign timer_s.match  = timer_period_match_in;

  // duty value as packed from a write word
  assign wr_duty = {reg_wdata_in[DUTY_HI_MSB:DUTY_HI_LSB],
                    reg_wdata_in[DUTY_LO_MSB:DUTY_LO_LSB]};

  // register writes, reads and reset in one next-state process
  always_comb begin
    d       = q;
    d.rdata = '0;
    // writes: software may rewrite duty at any time, the
    // channel only picks it up at the next period match
    if (reg_write_in) begin
      for (int i = 0; i < NCH; i++) begin
        if (reg_addr_in == DUTY_ADDR[i]) begin
          d.duty[i] = wr_duty;
        end
        if (reg_addr_in == CTRL_ADDR[i]) begin
          d.enable[i]   = reg_wdata_in[CTRL_EN_BIT];
          d.polarity[i] = reg_wdata_in[CTRL_POL_BIT];
        end
      end
    end
    // reads: answer stands only in the following cycle
    if (reg_read_in) begin
      for (int i = 0; i < NCH; i++) begin
        if (reg_addr_in == DUTY_ADDR[i]) begin
          d.rdata = {q.duty[i], {DUTY_PAD_W{1'b0}}};
        end
        if (reg_addr_in == CTRL_ADDR[i]) begin
          d.rdata[CTRL_EN_BIT]  = q.enable[i];
          d.rdata[CTRL_OUT_BIT] = wave_s[i];
          d.rdata[CTRL_POL_BIT] = q.polarity[i];
        end
      end
    end
    // reset clears control but leaves duty alone; writes during
    // reset are dropped so the old duty really survives
    if (rst_in) begin
      d.duty     = q.duty;
      d.enable   = {NCH{CTRL_RESET[CTRL_EN_BIT]}};
      d.polarity = {NCH{CTRL_RESET[CTRL_POL_BIT]}};
      d.rdata    = '0;
    end
  end

  // duty has no power-on value; a simulator shows unknown until written
  always_ff @(posedge clk_sys_in) begin
    q <= d;
  end

  // one compare channel per output
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    tbpc_channel #(
      .DW          (DUTY_W)
    ) u_chan (
      .clk_sys_in  (clk_sys_in),
      .rst_in      (rst_in),
      .enable_in   (q.enable[g]),
      .polarity_in (q.polarity[g]),
      .duty_in     (q.duty[g]),
      .timer_in    (timer_s),
      .wave_out    (wave_s[g])
    );
  end

  // both outputs come straight from flip-flops
  assign reg_rdata_out    = q.rdata;
  assign channel_wave_out = wave_s;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // channel a duty as held, for readback checks
  logic [DUTY_W-1:0] duty_a;
  assign duty_a = q.duty[0];

  chk_ctrl_after_reset: assert property (
    $past(rst_in) |-> q.enable == '0 && q.polarity == '0 && reg_rdata_out == '0)
    else $error("control not cleared by reset");
  chk_duty_kept_reset: assert property (
    $past(rst_in) |-> $stable(q.duty))
    else $error("duty changed across reset");
  chk_enable_write: assert property (
    reg_write_in && reg_addr_in == CTRL_ADDR[0]
    |=> q.enable[0] == $past(reg_wdata_in[CTRL_EN_BIT]))
    else $error("enable bit not written");
  chk_polarity_write: assert property (
    reg_write_in && reg_addr_in == CTRL_ADDR[1]
    |=> q.polarity[1] == $past(reg_wdata_in[CTRL_POL_BIT]))
    else $error("polarity bit not written");
  chk_status_readback: assert property (
    reg_read_in && reg_addr_in == CTRL_ADDR[0]
    |=> reg_rdata_out[CTRL_OUT_BIT] == $past(channel_wave_out[0]))
    else $error("status bit does not show output level");
  chk_duty_write_pack: assert property (
    reg_write_in && reg_addr_in == DUTY_ADDR[0] && !rst_in
    |=> duty_a == $past(wr_duty))
    else $error("duty write mispacked");
  chk_duty_readback: assert property (
    reg_read_in && reg_addr_in == DUTY_ADDR[0]
    |=> reg_rdata_out == {$past(duty_a), {DUTY_PAD_W{1'b0}}})
    else $error("duty readback wrong");
  chk_idle_rdata_zero: assert property (
    !reg_read_in |=> reg_rdata_out == '0)
    else $error("read data outside read answer");
  chk_duty_write_hold: assert property (
    !(reg_write_in && reg_addr_in == DUTY_ADDR[0]) |=> $stable(duty_a))
    else $error("duty changed without write");

  // channel b duty as held, so both channels get the same register checks
  logic [DUTY_W-1:0] duty_b;
  assign duty_b = q.duty[1];

  chk_enable_write_b: assert property (
    reg_write_in && reg_addr_in == CTRL_ADDR[1]
    |=> q.enable[1] == $past(reg_wdata_in[CTRL_EN_BIT]))
    else $error("channel b enable bit not written");
  chk_polarity_write_a: assert property (
    reg_write_in && reg_addr_in == CTRL_ADDR[0]
    |=> q.polarity[0] == $past(reg_wdata_in[CTRL_POL_BIT]))
    else $error("channel a polarity bit not written");
  chk_status_read_b: assert property (
    reg_read_in && reg_addr_in == CTRL_ADDR[1]
    |=> reg_rdata_out[CTRL_OUT_BIT] == $past(channel_wave_out[1]))
    else $error("channel b status bit does not show output level");
  chk_duty_pack_b: assert property (
    reg_write_in && reg_addr_in == DUTY_ADDR[1]
    |=> duty_b == $past(wr_duty))
    else $error("channel b duty write mispacked");
  chk_duty_read_b: assert property (
    reg_read_in && reg_addr_in == DUTY_ADDR[1]
    |=> reg_rdata_out == {$past(duty_b), {DUTY_PAD_W{1'b0}}})
    else $error("channel b duty readback wrong");
  chk_duty_hold_b: assert property (
    !(reg_write_in && reg_addr_in == DUTY_ADDR[1]) |=> $stable(duty_b))
    else $error("channel b duty changed without write");

endmodule

/* File: core/tbpc_pkg.sv */
package tbpc_pkg;

  // widths of the register port and the time base
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned DUTY_W = 10;
  localparam int unsigned TMR_W  = 8;
  localparam int unsigned LOW_W  = 2;
  localparam int unsigned CHAN_N = 2;

  // register addresses, channel a at index 0
  localparam logic [CHAN_N-1:0][ADDR_W-1:0] DUTY_ADDR = {12'h318, 12'h314};
  localparam logic [CHAN_N-1:0][ADDR_W-1:0] CTRL_ADDR = {12'h31a, 12'h316};

  // control register fields
  localparam int unsigned CTRL_EN_BIT  = 7;
  localparam int unsigned CTRL_OUT_BIT = 5;
  localparam int unsigned CTRL_POL_BIT = 4;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  // duty register fields
  localparam int unsigned DUTY_HI_MSB = 15;
  localparam int unsigned DUTY_HI_LSB = 8;
  localparam int unsigned DUTY_LO_MSB = 7;
  localparam int unsigned DUTY_LO_LSB = 6;
  localparam int unsigned DUTY_PAD_W  = 6;

  // shared timer as seen by each channel
  typedef struct packed {
    logic [TMR_W-1:0] count;
    logic [LOW_W-1:0] low;
    logic [TMR_W-1:0] period;
    logic             match;
  } tbpc_timer_t;

  // software visible register state
  typedef struct packed {
    logic [CHAN_N-1:0]             enable;
    logic [CHAN_N-1:0]             polarity;
    logic [CHAN_N-1:0][DUTY_W-1:0] duty;
    logic [DATA_W-1:0]             rdata;
  } tbpc_regs_t;

  // per channel compare state
  typedef struct packed {
    logic [DUTY_W-1:0] cmp;
    logic              active;
    logic              wave;
  } tbpc_chan_t;

endpackage

/* File: core/tbpc_channel.sv */
`timescale 1ns/1ns

module tbpc_channel
  import tbpc_pkg::*;
#(
  parameter int unsigned DW = DUTY_W
) (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // settings from the register file
  input  wire logic              enable_in,
  input  wire logic              polarity_in,
  input  wire logic [DW-1:0]     duty_in,
  // shared timer
  input  wire tbpc_timer_t       timer_in,
  // waveform
  output logic                   wave_out
);

  tbpc_chan_t       q;
  tbpc_chan_t       d;
  logic [DW-1:0]    time_base;
  logic             full_on;

  // timer count extended by the low phase bits, so rate follows clk
  assign time_base = {timer_in.count, timer_in.low};
  // compare beyond the period can never be reached
  assign full_on   = q.cmp[DW-1:LOW_W] > timer_in.period;

  // set at the period event, clear on compare equal
  always_comb begin
    d = q;
    if (!enable_in) begin
      d.active = 1'b0;
    end else if (timer_in.match) begin
      d.cmp    = duty_in;
      d.active = (duty_in != '0);
    end else if (time_base == q.cmp && !full_on) begin
      d.active = 1'b0;
    end
    d.wave = d.active ^ polarity_in;
    if (rst_in) begin
      d = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    q <= d;
  end

  assign wave_out = q.wave;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_disabled_idle_level: assert property (
    !enable_in |=> (wave_out == $past(polarity_in)) && !q.active)
    else $error("disabled channel left its idle level");
  chk_buffer_load_match: assert property (
    enable_in && timer_in.match |=> q.cmp == $past(duty_in))
    else $error("compare buffer not loaded at period match");
  chk_buffer_hold_else: assert property (
    !(enable_in && timer_in.match) |=> $stable(q.cmp))
    else $error("compare buffer changed outside period match");
  chk_zero_duty_idle: assert property (
    enable_in && timer_in.match && duty_in == '0 |=> !q.active)
    else $error("zero duty went active");
  chk_period_sets_active: assert property (
    enable_in && timer_in.match && duty_in != '0 |=> q.active)
    else $error("period event did not set output");
  chk_equal_clears: assert property (
    enable_in && !timer_in.match && time_base == q.cmp && !full_on |=> !q.active)
    else $error("compare equal did not clear output");
  chk_full_on_stays: assert property (
    q.active && enable_in && !timer_in.match && full_on |=> q.active)
    else $error("full duty output was cleared");

endmodule

/* File: test/tbpc_timer_model.sv */
`timescale 1ns/1ns

module tbpc_timer_model
  import tbpc_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // period loaded by software
  input  wire logic [TMR_W-1:0] period_in,
  // time base to the channels
  output logic      [TMR_W-1:0] count_out,
  output logic      [LOW_W-1:0] low_out,
  output logic                  match_out
);
  // match on the last phase so the timer clears on the next edge
  assign match_out = (count_out == period_in) && (low_out == 2'h3);

  // prescale 1:1, so low bits are the raw clock phase
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count_out <= 8'h00;
      low_out   <= 2'h0;
    end else begin
      low_out <= low_out + 2'h1;
      if (match_out) begin
        count_out <= 8'h00;
      end else if (low_out == 2'h3) begin
        count_out <= count_out + 8'h01;
      end
    end
  end
endmodule

/* File: test/test_ten_bit_pwm_channels.sv */
`timescale 1ns/1ns

module test_ten_bit_pwm_channels import tbpc_pkg::*;;
  logic        clk_sys;
  logic        rst;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [7:0]  count;
  logic [1:0]  low;
  logic [7:0]  period;
  logic        match;
  logic [1:0]  wave;
  int          miscompares;
  int          samples_checked;
  int          cycles;
  logic [9:0]  duties [5] = '{10'h000, 10'h006, 10'h00d, 10'h010, 10'h3ff};

  tbpc_top tbpc_top_inst (
    .clk_sys_in(clk_sys), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
    .base_timer_count_in(count), .time_base_low_in(low), .period_value_reg_in(period),
    .timer_period_match_in(match), .channel_wave_out(wave));

  tbpc_timer_model tbpc_timer_model_inst (
    .clk_sys_in(clk_sys), .rst_in(rst), .period_in(period),
    .count_out(count), .low_out(low), .match_out(match));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // a window of one whole period counts high cycles whatever its phase
  task automatic high_cycles(input int c, output logic [15:0] n);
    n = 16'h0000;
    repeat (16) begin
      @(posedge clk_sys);
      #1 n = n + 16'(wave[c]);
    end
  endtask

  function automatic logic [15:0] enc(input logic [9:0] d);
    return {d[9:2], d[1:0], 6'h00};
  endfunction

  // width is duty plus one: set and clear both land a cycle after their cause
  function automatic logic [15:0] exp_high(input logic [9:0] d, input logic polarity_select);
    logic [15:0] h;
    h = (d == 10'h000) ? 16'h0000 : ((d >= 10'h010) ? 16'h0010 : 16'(d) + 16'h0001);
    return polarity_select ? 16'h0010 - h : h;
  endfunction

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard, the sequence needs well under two thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    logic [15:0] v;
    rst = 1'b1;
    addr = 12'h000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    period = 8'h03;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(12'h317, 16'h0000);
    for (int c = 0; c < 2; c++) begin
      rd_chk(CTRL_ADDR[c], 16'h0000);
      foreach (duties[i]) begin
        for (int p = 0; p < 2; p++) begin
          // control cleared before the duty load, as the setup order asks
          reg_wr(CTRL_ADDR[c], 16'h0000);
          reg_wr(DUTY_ADDR[c], enc(duties[i]) | 16'h003f);
          reg_wr(CTRL_ADDR[c], p[0] ? 16'h0090 : 16'h0080);
          repeat (32) @(posedge clk_sys);
          high_cycles(c, v);
          check(v, exp_high(duties[i], p[0]));
        end
        rd_chk(DUTY_ADDR[c], enc(duties[i]));
      end
      // control ahead of duty: the first period may be cut short, no pin here
      reg_wr(CTRL_ADDR[c], 16'h00a0);
      reg_wr(DUTY_ADDR[c], 16'hffc0);
      repeat (32) @(posedge clk_sys);
      rd_chk(CTRL_ADDR[c], 16'h00a0);
      reg_wr(DUTY_ADDR[c], 16'h0000);
      reg_wr(12'h317, 16'h0000);
      repeat (32) @(posedge clk_sys);
      rd_chk(CTRL_ADDR[c], 16'h0080);
      reg_wr(CTRL_ADDR[c], 16'h00df);
      repeat (32) @(posedge clk_sys);
      rd_chk(CTRL_ADDR[c], 16'h00b0);
      // inverted full duty sits low, so only a working disable can lift it
      reg_wr(DUTY_ADDR[c], 16'hffc0);
      repeat (32) @(posedge clk_sys);
      high_cycles(c, v);
      check(v, 16'h0000);
      reg_wr(CTRL_ADDR[c], 16'h0010);
      high_cycles(c, v);
      check(v, 16'h0010);
      rd_chk(CTRL_ADDR[c], 16'h0030);
    end
    // duty survives a mid-run reset, control does not
    reg_wr(DUTY_ADDR[0], enc(10'h2a5));
    reg_wr(CTRL_ADDR[0], 16'h0090);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1 check({14'h0000, wave}, 16'h0000);
    rd_chk(DUTY_ADDR[0], enc(10'h2a5));
    rd_chk(CTRL_ADDR[0], 16'h0000);
    wrap_up();
  end
endmodule
